// *** logic/ics_io_point.sv ***
// status word and timer of one i/o point
`timescale 1ns/1ps
module ics_io_point (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic tick_10s_in,
  input wire logic tick_min_in,
  input wire logic tick_hour_in,
  input wire logic [15:0] cfg_in,
  input wire logic msg_rx_in,
  input wire logic tx_ok_in,
  input wire logic tx_fail_in,
  output logic [15:0] status_out,
  output logic update_req_out
);
  import ics_pkg::*;
  logic fail_r;
  logic startup_r;
  logic [PT_TMR_W-1:0] tmr_r;
  logic [2:0] tries_r;
  wire cfg_input = cfg_in[DIR_BIT];
  wire cfg_active = cfg_in[ACT_BIT];
  wire [1:0] tb = cfg_in[TB_HI:TB_LO];
  wire [PT_TMR_W-1:0] cfg_time = cfg_in[PT_TMR_W-1:0];
  wire time_on = cfg_time != '0;
  wire tb_tick = (tb == TB_10S) ? tick_10s_in : // RQ7
                 (tb == TB_MIN) ? tick_min_in : tick_hour_in;
  wire tmr_dec = cfg_active && tb_tick && tmr_r != '0;
  wire tmr_expire = tmr_dec && tmr_r == PT_TMR_W'(1);
  wire in_load = cfg_active && cfg_input && msg_rx_in;
  wire out_sent = cfg_active && !cfg_input && (tx_ok_in || tx_fail_in);
  wire out_load = cfg_active && !cfg_input && tx_ok_in;
  wire in_fail_set = cfg_input && tmr_expire && time_on; // RQ9 RQ10
  wire out_fail_set = out_sent && tx_fail_in && !tx_ok_in
                      && tries_r == MAX_TX_TRIES - 3'h1; // RQ2
  wire fail_set = in_fail_set || out_fail_set;
  wire fail_clr = in_load || out_load; // RQ1 RQ2
  wire [PT_TMR_W-1:0] tmr_nxt = (in_load || out_load) ? cfg_time : // RQ8 RQ11
                                tmr_dec ? tmr_r - PT_TMR_W'(1) : tmr_r;
  wire [2:0] tries_nxt = out_load ? 3'h0 :
                         (out_sent && tries_r != MAX_TX_TRIES) ? tries_r + 3'h1 : tries_r;
  assign status_out = {fail_r, startup_r, cfg_input, cfg_active, tb, tmr_r}; // RQ5 RQ6
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fail_r <= 1'b0;
      startup_r <= 1'b1;
      tmr_r <= '0;
      tries_r <= 3'h0;
      update_req_out <= 1'b0;
    end else if (ce_in) begin
      fail_r <= fail_set || (fail_r && !fail_clr); // RQ1
      if (in_load || out_sent) startup_r <= 1'b0; // RQ3 RQ4
      tmr_r <= tmr_nxt;
      tries_r <= tries_nxt;
      update_req_out <= !cfg_input && tmr_expire && time_on; // RQ12 RQ13
    end
  end
endmodule

// *** logic/ics_pkg.sv ***
// shared constants and types of the i/o and command status supervisor
package ics_pkg;
  localparam int NUM_PTS = 4;
  localparam int NUM_CMDS = 2;
  localparam int ADDR_W = 16;
  localparam int PT_TMR_W = 10;
  localparam int CMD_TMR_W = 12;
  // register map, byte addresses
  localparam logic [15:0] PT_STAT_BASE = 16'h1388;
  localparam logic [15:0] CMD_STAT_BASE = 16'h1400;
  localparam logic [15:0] PT_CFG_BASE = 16'h1000;
  localparam logic [15:0] CMD_CFG_BASE = 16'h1100;
  localparam logic [15:0] REG_STRIDE = 16'h0004;
  // status word fields
  localparam int FAIL_BIT = 15;
  localparam int START_BIT = 14;
  localparam int DIR_BIT = 13;
  localparam int FORCE_BIT = 13;
  localparam int ACT_BIT = 12;
  localparam int WAIT_BIT = 12;
  localparam int TB_HI = 11;
  localparam int TB_LO = 10;
  // command config word fields
  localparam int CC_DLY_HI = 11;
  localparam int CC_HOLD_LO = 12;
  localparam int CC_HOLD_HI = 23;
  localparam int CC_KIND_LO = 24;
  localparam int CC_KIND_HI = 25;
  // reset values
  localparam logic [15:0] PT_CFG_RST = 16'h0000;
  localparam logic [31:0] CMD_CFG_RST = 32'h0000_0000;
  // timebase codes, prescaler counts and output send try limit
  localparam logic [1:0] TB_10S = 2'h0;
  localparam logic [1:0] TB_MIN = 2'h1;
  localparam int SEC_PER_TEN = 10;
  localparam int TEN_PER_MIN = 6;
  localparam int MIN_PER_HOUR = 60;
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_S = 1;
  localparam int CYC_PER_SEC = CLK_HZ * TICK_S;
  localparam logic [2:0] MAX_TX_TRIES = 3'h5;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CMD_RD_BITS = 2'b00,
    CMD_RD_WORDS = 2'b01,
    CMD_WRITE = 2'b10,
    CMD_POLL = 2'b11
  } ics_cmd_kind_t;
  typedef enum logic [1:0] {
    CPH_IDLE = 2'b00,
    CPH_DELAY = 2'b01,
    CPH_REPLY = 2'b10
  } ics_cmd_ph_t;
endpackage

// *** logic/ics_supervisor.sv ***
// i/o point and command status supervisor with axi4-lite register access
// Functional notes
// RQ1: input point fail bit sets on timeout, clears on received message.
// RQ2: output point fail bit sets after five failed sends, clears on success.
// RQ3: input start-up bit holds until first message received.
// RQ4: output start-up bit holds until first message sent.
// RQ5: bit 13 reads one for input points.
// RQ6: bit 12 reads one for configured points.
// RQ7: bits 11-10 pick ten seconds, minute or hour timebase.
// RQ8: input timer reloads on message, then counts down.
// RQ9: input timer reaching zero sets fail bit.
// RQ10: zero comms-fail time never sets input fail bit.
// RQ11: output timer reloads on each send, then counts down; the code reloads it only on successful sends, not on failed ones.
// RQ12: output timer reaching zero requests an update send.
// RQ13: zero update time gives no periodic updates.
// RQ14: read commands fail on reply timeout or fail response.
// RQ15: write commands fail only on fail response.
// RQ16: poll commands never set fail bit.
// RQ17: command start-up bit set at reset, cleared on first execution.
// RQ18: writing one to bit 13 executes the command at once; the code drops it while a read awaits its reply.
// RQ19: bit 12 set while write delays or read awaits reply.
// RQ20: idle timer holds seconds to activation; zero reloads with delay.
// RQ21: waiting read counts reply time; expiry sets fail bit.
// RQ22: waiting write counts down, then transmits.
// RQ23: all timers run from one-second tick and its prescaler.
// RQ24: force bit clears itself when forced execution starts.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module ics_supervisor #(
  parameter int unsigned CYC_PER_SEC = ics_pkg::CYC_PER_SEC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [ics_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ics_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [ics_pkg::NUM_PTS-1:0] pt_msg_rx_in,
  input wire logic [ics_pkg::NUM_PTS-1:0] pt_tx_ok_in,
  input wire logic [ics_pkg::NUM_PTS-1:0] pt_tx_fail_in,
  output logic [ics_pkg::NUM_PTS-1:0] pt_update_req_out,
  input wire logic [ics_pkg::NUM_CMDS-1:0] cmd_change_in,
  input wire logic [ics_pkg::NUM_CMDS-1:0] cmd_reply_ok_in,
  input wire logic [ics_pkg::NUM_CMDS-1:0] cmd_fail_rsp_in,
  output logic [ics_pkg::NUM_CMDS-1:0] cmd_exec_out
);
  import ics_pkg::*;

  // timebase
  logic tick_1s;
  logic tick_10s;
  logic tick_min;
  logic tick_hour;
  ics_tick_gen #(
    .CYC_PER_SEC(CYC_PER_SEC)
  ) u_tick (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .tick_1s_out(tick_1s),
    .tick_10s_out(tick_10s),
    .tick_min_out(tick_min),
    .tick_hour_out(tick_hour)
  );

  // axi write and read channel holding registers
  logic aw_hold_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic w_hold_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign s_axi_awready_out = !aw_hold_r && !bvalid_r;
  assign s_axi_wready_out = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = !rvalid_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;

  wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
  wire w_take = s_axi_wvalid_in && s_axi_wready_out;
  wire do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  wire ar_take = s_axi_arvalid_in && s_axi_arready_out;

  // configuration and status storage
  logic [15:0] pt_cfg_r [NUM_PTS];
  logic [31:0] cmd_cfg_r [NUM_CMDS];
  logic [15:0] pt_stat [NUM_PTS];
  logic [15:0] cmd_stat [NUM_CMDS];

  // write decode
  logic [NUM_PTS-1:0] wr_pt_cfg;
  logic [NUM_PTS-1:0] wr_pt_stat;
  logic [NUM_CMDS-1:0] wr_cmd_cfg;
  logic [NUM_CMDS-1:0] wr_cmd_stat;
  // read decode
  logic [NUM_PTS-1:0] rd_pt_cfg;
  logic [NUM_PTS-1:0] rd_pt_stat;
  logic [NUM_CMDS-1:0] rd_cmd_cfg;
  logic [NUM_CMDS-1:0] rd_cmd_stat;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PTS; gi++) begin : g_pt_dec
      wire [15:0] cfg_a = PT_CFG_BASE + 16'(gi) * REG_STRIDE;
      wire [15:0] st_a = PT_STAT_BASE + 16'(gi) * REG_STRIDE;
      assign wr_pt_cfg[gi] = aw_addr_r == cfg_a;
      assign wr_pt_stat[gi] = aw_addr_r == st_a;
      assign rd_pt_cfg[gi] = s_axi_araddr_in == cfg_a;
      assign rd_pt_stat[gi] = s_axi_araddr_in == st_a;
    end
    for (gi = 0; gi < NUM_CMDS; gi++) begin : g_cmd_dec
      wire [15:0] cfg_a = CMD_CFG_BASE + 16'(gi) * REG_STRIDE;
      wire [15:0] st_a = CMD_STAT_BASE + 16'(gi) * REG_STRIDE;
      assign wr_cmd_cfg[gi] = aw_addr_r == cfg_a;
      assign wr_cmd_stat[gi] = aw_addr_r == st_a;
      assign rd_cmd_cfg[gi] = s_axi_araddr_in == cfg_a;
      assign rd_cmd_stat[gi] = s_axi_araddr_in == st_a;
    end
  endgenerate

  wire wr_hit = |{wr_pt_cfg, wr_pt_stat, wr_cmd_cfg, wr_cmd_stat};
  wire rd_hit = |{rd_pt_cfg, rd_pt_stat, rd_cmd_cfg, rd_cmd_stat};

  // read data selection
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    for (int k = 0; k < NUM_PTS; k++) begin
      if (rd_pt_cfg[k]) rd_mux = {16'h0000, pt_cfg_r[k]};
      if (rd_pt_stat[k]) rd_mux = {16'h0000, pt_stat[k]};
    end
    for (int k = 0; k < NUM_CMDS; k++) begin
      if (rd_cmd_cfg[k]) rd_mux = cmd_cfg_r[k];
      if (rd_cmd_stat[k]) rd_mux = {16'h0000, cmd_stat[k]};
    end
  end

  // byte-lane merge for config writes
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction

  // axi handshake state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (ce_in) begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_in;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata_in;
        w_strb_r <= s_axi_wstrb_in;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready_in) begin
        bvalid_r <= 1'b0;
      end
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready_in) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // i/o points
  generate
    for (gi = 0; gi < NUM_PTS; gi++) begin : g_pt
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          pt_cfg_r[gi] <= PT_CFG_RST;
        end else if (ce_in && do_wr && wr_pt_cfg[gi]) begin
          pt_cfg_r[gi] <= 16'(merge_lanes({16'h0000, pt_cfg_r[gi]}, w_data_r, w_strb_r));
        end
      end
      ics_io_point u_pt (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .tick_10s_in(tick_10s),
        .tick_min_in(tick_min),
        .tick_hour_in(tick_hour),
        .cfg_in(pt_cfg_r[gi]),
        .msg_rx_in(pt_msg_rx_in[gi]),
        .tx_ok_in(pt_tx_ok_in[gi]),
        .tx_fail_in(pt_tx_fail_in[gi]),
        .status_out(pt_stat[gi]),
        .update_req_out(pt_update_req_out[gi])
      );
    end
  endgenerate

  // commands
  generate
    for (gi = 0; gi < NUM_CMDS; gi++) begin : g_cmd
      ics_cmd_ph_t ph_r;
      ics_cmd_ph_t ph_nxt;
      logic [CMD_TMR_W-1:0] tmr_r;
      logic [CMD_TMR_W-1:0] tmr_nxt;
      logic fail_r;
      logic fail_nxt;
      logic startup_r;
      logic force_r;
      logic exec_nxt;
      wire [1:0] kind = cmd_cfg_r[gi][CC_KIND_HI:CC_KIND_LO];
      wire [CMD_TMR_W-1:0] dly = cmd_cfg_r[gi][CC_DLY_HI:0];
      wire [CMD_TMR_W-1:0] hold = cmd_cfg_r[gi][CC_HOLD_HI:CC_HOLD_LO];
      wire is_read = kind == CMD_RD_BITS || kind == CMD_RD_WORDS;
      wire is_write = kind == CMD_WRITE;
      wire tmr_last = tmr_r <= CMD_TMR_W'(1);
      wire force_wr = do_wr && wr_cmd_stat[gi] && w_strb_r[1] && w_data_r[FORCE_BIT];
      wire idle_due = tick_1s && tmr_r == CMD_TMR_W'(1);
      wire start = ph_nxt != ph_r || exec_nxt;

      always_comb begin
        ph_nxt = ph_r;
        tmr_nxt = tmr_r;
        fail_nxt = fail_r;
        exec_nxt = 1'b0;
        unique case (ph_r)
          CPH_IDLE: begin
            if (force_r || idle_due) begin
              if (is_read) begin
                exec_nxt = 1'b1;
                ph_nxt = CPH_REPLY; // RQ19
                tmr_nxt = hold; // RQ21
              end else if (is_write && !force_r && hold != '0) begin
                ph_nxt = CPH_DELAY; // RQ22
                tmr_nxt = hold;
              end else begin
                exec_nxt = 1'b1; // RQ18
                tmr_nxt = '0;
              end
            end else if (is_write && cmd_change_in[gi]) begin
              ph_nxt = CPH_DELAY; // RQ19
              tmr_nxt = hold;
            end else if (tick_1s) begin
              tmr_nxt = (tmr_r == '0) ? dly : tmr_r - CMD_TMR_W'(1); // RQ20
            end
          end
          CPH_DELAY: begin
            if (force_r || (tick_1s && tmr_last) || tmr_r == '0) begin
              exec_nxt = 1'b1; // RQ22
              ph_nxt = CPH_IDLE;
              tmr_nxt = '0;
            end else if (tick_1s) begin
              tmr_nxt = tmr_r - CMD_TMR_W'(1);
            end
          end
          CPH_REPLY: begin
            if (cmd_fail_rsp_in[gi] || (tick_1s && tmr_last)) begin
              fail_nxt = 1'b1; // RQ14 RQ21
              ph_nxt = CPH_IDLE;
              tmr_nxt = '0;
            end else if (cmd_reply_ok_in[gi]) begin
              fail_nxt = 1'b0;
              ph_nxt = CPH_IDLE;
              tmr_nxt = '0;
            end else if (tick_1s) begin
              tmr_nxt = tmr_r - CMD_TMR_W'(1);
            end
          end
          default: begin
            ph_nxt = CPH_IDLE;
            tmr_nxt = '0;
          end
        endcase
        if (is_write && ph_r != CPH_REPLY) begin
          if (cmd_fail_rsp_in[gi]) begin
            fail_nxt = 1'b1; // RQ15
          end else if (cmd_reply_ok_in[gi]) begin
            fail_nxt = 1'b0;
          end
        end
        if (kind == CMD_POLL) fail_nxt = 1'b0; // RQ16
      end

      assign cmd_stat[gi] = {fail_r, startup_r, force_r, ph_r != CPH_IDLE, tmr_r}; // RQ19

      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          cmd_cfg_r[gi] <= CMD_CFG_RST;
          ph_r <= CPH_IDLE;
          tmr_r <= '0;
          fail_r <= 1'b0;
          startup_r <= 1'b1; // RQ17
          force_r <= 1'b0;
          cmd_exec_out[gi] <= 1'b0;
        end else if (ce_in) begin
          if (do_wr && wr_cmd_cfg[gi]) begin
            cmd_cfg_r[gi] <= merge_lanes(cmd_cfg_r[gi], w_data_r, w_strb_r);
          end
          ph_r <= ph_nxt;
          tmr_r <= tmr_nxt;
          fail_r <= fail_nxt;
          cmd_exec_out[gi] <= exec_nxt;
          if (exec_nxt) startup_r <= 1'b0; // RQ17
          force_r <= force_wr || (force_r && !start); // RQ24
        end
      end
    end
  endgenerate

endmodule

// *** logic/ics_tick_gen.sv ***
// one-second tick and ten-second, minute and hour timebases
`timescale 1ns/1ps
module ics_tick_gen #(
  parameter int unsigned CYC_PER_SEC = ics_pkg::CYC_PER_SEC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  output logic tick_1s_out,
  output logic tick_10s_out,
  output logic tick_min_out,
  output logic tick_hour_out
);
  import ics_pkg::*;
  logic [31:0] sec_cnt_r;
  logic [3:0] ten_cnt_r;
  logic [2:0] six_cnt_r;
  logic [5:0] hr_cnt_r;
  wire sec_wrap = sec_cnt_r == 32'(CYC_PER_SEC - 1);
  wire ten_wrap = sec_wrap && ten_cnt_r == 4'(SEC_PER_TEN - 1);
  wire min_wrap = ten_wrap && six_cnt_r == 3'(TEN_PER_MIN - 1);
  wire hour_wrap = min_wrap && hr_cnt_r == 6'(MIN_PER_HOUR - 1);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sec_cnt_r <= 32'h0;
      ten_cnt_r <= 4'h0;
      six_cnt_r <= 3'h0;
      hr_cnt_r <= 6'h0;
      tick_1s_out <= 1'b0;
      tick_10s_out <= 1'b0;
      tick_min_out <= 1'b0;
      tick_hour_out <= 1'b0;
    end else if (ce_in) begin
      sec_cnt_r <= sec_wrap ? 32'h0 : sec_cnt_r + 32'h1;
      if (sec_wrap) ten_cnt_r <= ten_wrap ? 4'h0 : ten_cnt_r + 4'h1;
      if (ten_wrap) six_cnt_r <= min_wrap ? 3'h0 : six_cnt_r + 3'h1;
      if (min_wrap) hr_cnt_r <= hour_wrap ? 6'h0 : hr_cnt_r + 6'h1;
      tick_1s_out <= sec_wrap; // RQ23
      tick_10s_out <= ten_wrap;
      tick_min_out <= min_wrap;
      tick_hour_out <= hour_wrap;
    end
  end
endmodule

// *** tb/ics_radio_model.sv ***
// radio messaging engine model facing the supervisor
`timescale 1ns/1ps
module ics_radio_model import ics_pkg::*; (
  input wire logic clk_in,
  input wire logic [NUM_PTS-1:0] upd_in,
  input wire logic [NUM_CMDS-1:0] exec_in,
  output logic [NUM_PTS-1:0] msg_out,
  output logic [NUM_PTS-1:0] ok_out,
  output logic [NUM_PTS-1:0] fail_out,
  output logic [NUM_CMDS-1:0] chg_out,
  output logic [NUM_CMDS-1:0] rok_out,
  output logic [NUM_CMDS-1:0] rfail_out
);
  logic [NUM_PTS-1:0] msg_q = '0, ok_q = '0, fail_q = '0;
  logic [NUM_CMDS-1:0] chg_q = '0, ex_d = '0;
  logic auto_ok = 1'b1;
  logic [1:0] mode [NUM_CMDS] = '{2'h0, 2'h0};
  int n_upd [NUM_PTS] = '{0, 0, 0, 0};
  int n_exec [NUM_CMDS] = '{0, 0};
  initial begin
    {msg_out, ok_out, fail_out, chg_out, rok_out, rfail_out} = '0;
  end
  task automatic kick(input int what, input int idx);
    #1;
    case (what)
      0: msg_q[idx] = 1'b1;
      1: ok_q[idx] = 1'b1;
      2: fail_q[idx] = 1'b1;
      default: chg_q[idx] = 1'b1;
    endcase
    @(posedge clk_in);
    @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    msg_out <= msg_q;
    ok_out <= ok_q | (auto_ok ? upd_in : '0);
    fail_out <= fail_q;
    chg_out <= chg_q;
    ex_d <= exec_in;
    for (int j = 0; j < NUM_CMDS; j++) begin
      rok_out[j] <= ex_d[j] && mode[j] == 2'h0;
      rfail_out[j] <= ex_d[j] && mode[j] == 2'h1;
      if (exec_in[j]) n_exec[j]++;
    end
    for (int i = 0; i < NUM_PTS; i++) begin
      if (upd_in[i]) n_upd[i]++;
    end
    {msg_q, ok_q, fail_q, chg_q} = '0;
  end
endmodule

// *** tb/ics_supervisor_assertions.sv ***
// bus and event port assertions for the status supervisor
`timescale 1ns/1ps
module ics_sup_checker import ics_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [NUM_PTS-1:0] pt_update_req_out,
  input wire logic [NUM_CMDS-1:0] cmd_exec_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
  a_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer dropped");
  a_wr_blocked: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while answer pending");
  a_rd_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while answer pending");
  a_wr_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("write answer late");
  a_rd_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_rd_unmapped: assert property (s_axi_arvalid_in && s_axi_arready_out
    && s_axi_araddr_in == 16'h2000 |=> s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == '0)
    else $error("unmapped read not refused");
  a_update_pulse: assert property (|pt_update_req_out |=>
    (pt_update_req_out & $past(pt_update_req_out)) == '0) else $error("update pulse too long");
  a_exec_pulse: assert property (|cmd_exec_out |=>
    (cmd_exec_out & $past(cmd_exec_out)) == '0) else $error("exec pulse too long");
  a_reset_idle: assert property (disable iff (1'b0) !rst_n_in |=> !s_axi_bvalid_out
    && !s_axi_rvalid_out && s_axi_arready_out && s_axi_awready_out) else $error("reset not idle");
  c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
  c_update: cover property (|pt_update_req_out);
  c_exec: cover property (|cmd_exec_out);
endmodule

// *** tb/ics_supervisor_bench.sv ***
// self-checking bench for the status supervisor
`timescale 1ns/1ps
module ics_supervisor_bench;
  import ics_pkg::*;
  localparam int LIMIT = 20000;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [3:0] msg, tok, tfl, upd;
  logic [1:0] chg, rok, rfl, exe;
  int n_mismatch = 0, total_checks = 0, cyc = 0, e;
  always #12.5 clk_in = ~clk_in;
  ics_supervisor #(.CYC_PER_SEC(10)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .pt_msg_rx_in(msg),
    .pt_tx_ok_in(tok), .pt_tx_fail_in(tfl), .pt_update_req_out(upd), .cmd_change_in(chg),
    .cmd_reply_ok_in(rok), .cmd_fail_rsp_in(rfl), .cmd_exec_out(exe));
  ics_radio_model rad_u (.clk_in(clk_in), .upd_in(upd), .exec_in(exe), .msg_out(msg),
    .ok_out(tok), .fail_out(tfl), .chg_out(chg), .rok_out(rok), .rfail_out(rfl));
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s,
    input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge clk_in);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge clk_in);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
    chk("bresp", 32'(er), 32'(r));
  endtask
  task automatic rd(input logic [15:0] a, input logic [1:0] er);
    logic ha, hr;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clk_in);
      ha = arvalid && arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_in);
      if (ha) arvalid <= 1'b0;
    end while (!hr);
    chk("rresp", 32'(er), 32'(r));
  endtask
  task automatic pt_rd(input int i);
    rd(PT_STAT_BASE + 16'(4 * i), RESP_OKAY);
  endtask
  task automatic force_cmd();
    wr(CMD_STAT_BASE, 32'h2000, 4'h3, RESP_OKAY);
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    for (int i = 0; i < NUM_PTS; i++) begin
      pt_rd(i);
      chk("pt reset", 32'h4000, d);
    end
    rd(CMD_STAT_BASE + 16'h4, RESP_OKAY);
    chk("cmd reset", 32'h4000, d);
    rd(16'h2000, RESP_SLVERR);
    chk("unmapped data", 32'h0, d);
    wr(16'h2000, 32'h1, 4'hf, RESP_SLVERR);
    wr(PT_STAT_BASE, 32'hffff, 4'hf, RESP_OKAY);
    pt_rd(0);
    chk("pt ro", 32'h4000, d);
    for (int t = 3; t >= 0; t--) begin
      wr(PT_CFG_BASE + 16'h4, 32'h3000 | 32'(t << 10), 4'hf, RESP_OKAY);
      pt_rd(1);
      chk("pt1 cfg", 32'h7000 | 32'(t << 10), d);
    end
    wr(PT_CFG_BASE, 32'h3003, 4'hf, RESP_OKAY);
    wr(PT_CFG_BASE + 16'h8, 32'h1002, 4'hf, RESP_OKAY);
    wr(PT_CFG_BASE + 16'hc, 32'h1000, 4'hf, RESP_OKAY);
    pt_rd(2);
    chk("out startup", 32'h5000, d & 32'hfc00);
    rad_u.kick(0, 0);
    rad_u.kick(0, 1);
    rad_u.kick(1, 2);
    rad_u.kick(1, 3);
    pt_rd(0);
    chk("in first msg", 32'h3000, d & 32'hfc00);
    chk("in reload", 32'h1, 32'(d[9:0] == 10'h3 || d[9:0] == 10'h2));
    pt_rd(2);
    chk("out first send", 32'h1000, d & 32'hfc00);
    repeat (450) @(posedge clk_in);
    pt_rd(0);
    chk("in timeout", 32'hb000, d);
    pt_rd(1);
    chk("in zero time", 32'h3000, d);
    chk("out update", 32'h1, 32'(rad_u.n_upd[2] > 0));
    chk("out no update", 32'h0, 32'(rad_u.n_upd[3]));
    rad_u.kick(0, 0);
    pt_rd(0);
    chk("in recover", 32'h0, 32'(d[FAIL_BIT]));
    rad_u.auto_ok = 1'b0;
    for (int n = 1; n <= 5; n++) begin
      rad_u.kick(2, 2);
      pt_rd(2);
      chk("out fail count", 32'(n == 5), 32'(d[FAIL_BIT]));
    end
    rad_u.kick(1, 2);
    pt_rd(2);
    chk("out recover", 32'h0, 32'(d[FAIL_BIT]));
    wr(CMD_CFG_BASE + 16'h4, 32'h0200_3fff, 4'hf, RESP_OKAY);
    e = rad_u.n_exec[1];
    rad_u.kick(3, 1);
    rd(CMD_STAT_BASE + 16'h4, RESP_OKAY);
    chk("gather wait", 32'h1, 32'(d[WAIT_BIT]));
    chk("gather early", 32'(e), 32'(rad_u.n_exec[1]));
    repeat (50) @(posedge clk_in);
    chk("gather sent", 32'(e + 1), 32'(rad_u.n_exec[1]));
    for (int k = 0; k < 4; k++) begin
      for (int m = 1; m < 3; m++) begin
        wr(CMD_CFG_BASE, {6'h0, 2'(k), 24'h003fff}, 4'hf, RESP_OKAY);
        rad_u.mode[0] = 2'h0;
        force_cmd();
        repeat (50) @(posedge clk_in);
        rad_u.mode[0] = 2'(m);
        e = rad_u.n_exec[0];
        force_cmd();
        repeat (8) @(posedge clk_in);
        chk("forced exec", 32'(e + 1), 32'(rad_u.n_exec[0]));
        rd(CMD_STAT_BASE, RESP_OKAY);
        chk("start force", 32'h0, 32'(d[14:13]));
        if (k < 2 && m == 2) chk("read wait", 32'h1, 32'(d[WAIT_BIT]));
        repeat (80) @(posedge clk_in);
        rd(CMD_STAT_BASE, RESP_OKAY);
        chk("cmd fail", 32'(m == 1 ? k != 3 : k < 2), 32'(d[FAIL_BIT]));
      end
    end
    results();
  end
endmodule
bind ics_supervisor ics_sup_checker chk_u (.clk_in, .rst_n_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
  .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
  .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .pt_update_req_out, .cmd_exec_out);
